// [core/llt_top.sv]
// Overview of operation
// - Table holds 4096 software-writable 12-bit entries.
// - Enabled table substitutes every pixel value.
// - Disabled, 12-bit format passes raw pixels.
// - Multiples of 8 take their entry unchanged.
// - Only every eighth entry affects output.
// - Between multiples, interpolate linearly between neighbours.
// - Above 4088 output entry 4088, no interpolation.
// - 8-bit format sends upper eight substitute bits; disabled, it sends upper eight raw bits.
// - Selector offers only the luminance table.
// - Value write stores at current index.
// - Enable bit one turns substitution on.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module llt_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [llt_pkg::LLT_APB_AW-1:0] paddr,
    input wire logic [llt_pkg::LLT_APB_DW-1:0] pwdata,
    output logic [llt_pkg::LLT_APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor pixel stream in.
    input wire logic pix_in_valid,
    input wire logic pix_in_last,
    input wire logic [llt_pkg::LLT_DATA_W-1:0] pix_in_data,
    // Pixel stream out to the formatter.
    output logic pix_out_valid,
    output logic pix_out_last,
    output logic [llt_pkg::LLT_DATA_W-1:0] pix_out_data
);
    import llt_pkg::*;

    // ------------------------------------------------------------------
    // Table memory
    // ------------------------------------------------------------------
    llt_mem_if mif ();

    llt_table_mem u_mem (
        .pclk(pclk),
        .mif(mif)
    );

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic access;
    logic done;
    logic hit;
    logic [LLT_ADDR_W-1:0] index_q;
    logic [LLT_ADDR_W-1:0] index_d;
    logic [LLT_DATA_W-1:0] value_q;
    logic [LLT_DATA_W-1:0] value_d;
    logic enable_q;
    logic enable_d;
    llt_fmt_t fmt_q;
    llt_fmt_t fmt_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [LLT_APB_DW-1:0] prdata_q;
    logic [LLT_APB_DW-1:0] prdata_d;
    logic [LLT_DATA_W-1:0] last_sub_q;
    logic [LLT_DATA_W-1:0] last_sub_d;
    logic pipe_busy;

    // One wait state keeps every bus output on a flip-flop; the transfer
    // completes on the edge where pready_q is seen high.
    assign access = psel && penable && !pready_q;
    assign done = psel && penable && pready_q;

    // Address decode.
    always_comb begin
        unique case (paddr)
            LLT_OFS_SELECTOR,
            LLT_OFS_INDEX,
            LLT_OFS_VALUE,
            LLT_OFS_ENABLE,
            LLT_OFS_FORMAT,
            LLT_OFS_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Table writes go straight to memory at the completing edge.
    always_comb begin
        mif.wr_en = done && pwrite && (paddr == LLT_OFS_VALUE);
        mif.wr_addr = index_q;
        mif.wr_data = pwdata[LLT_DATA_W-1:0];
    end

    // Register next values; writes land only at transfer completion.
    always_comb begin
        index_d = index_q;
        value_d = value_q;
        enable_d = enable_q;
        fmt_d = fmt_q;
        if (done && pwrite) begin
            unique case (paddr)
                LLT_OFS_INDEX: index_d = pwdata[LLT_ADDR_W-1:0];
                LLT_OFS_VALUE: value_d = pwdata[LLT_DATA_W-1:0];
                LLT_OFS_ENABLE: enable_d = pwdata[0];
                LLT_OFS_FORMAT: fmt_d = llt_fmt_t'(pwdata[0]);
                default: ;
            endcase
        end
    end

    // Answer for the access phase.  The selector has a single legal
    // code; any other written code is refused with an error.
    always_comb begin
        pready_d = access;
        pslverr_d = 1'b0;
        prdata_d = LLT_RST_RDATA;
        if (access) begin
            if (!hit) begin
                pslverr_d = 1'b1;
            end else if (pwrite && paddr == LLT_OFS_SELECTOR) begin
                pslverr_d = (pwdata != LLT_SEL_LUMINANCE);
            end else if (!pwrite) begin
                unique case (paddr)
                    LLT_OFS_SELECTOR: prdata_d = LLT_SEL_LUMINANCE;
                    LLT_OFS_INDEX: prdata_d[LLT_ADDR_W-1:0] = index_q;
                    LLT_OFS_VALUE: prdata_d[LLT_DATA_W-1:0] = value_q;
                    LLT_OFS_ENABLE: prdata_d[0] = enable_q;
                    LLT_OFS_FORMAT: prdata_d[0] = fmt_q;
                    LLT_OFS_STATUS: begin
                        prdata_d[0] = pipe_busy;
                        prdata_d[LLT_STAT_LAST_LSB +: LLT_DATA_W] =
                            last_sub_q;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Register state of the bus slave.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q <= LLT_RST_INDEX;
            value_q <= LLT_RST_VALUE;
            enable_q <= 1'b0;
            fmt_q <= LLT_FMT_MONO12;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= LLT_RST_RDATA;
        end else begin
            index_q <= index_d;
            value_q <= value_d;
            enable_q <= enable_d;
            fmt_q <= fmt_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // Pixel stage 1: neighbour lookup
    // ------------------------------------------------------------------
    logic top_range;
    logic [LLT_FRAC_W-1:0] frac_d;
    logic [LLT_FRAC_W-1:0] frac_q;
    logic s1_valid_q;
    logic s1_last_q;
    logic [LLT_DATA_W-1:0] s1_raw_q;

    // Lower neighbour is the pixel rounded down to a multiple of eight,
    // so off-grid entries are never addressed.  From the last grid point
    // upward both reads hit that point and the weight is zero.
    always_comb begin
        top_range = (pix_in_data >= LLT_LAST_IDX);
        if (top_range) begin
            mif.rd_addr_lo = LLT_LAST_IDX;
            mif.rd_addr_hi = LLT_LAST_IDX;
            frac_d = '0;
        end else begin
            mif.rd_addr_lo = pix_in_data & LLT_BLK_MASK;
            mif.rd_addr_hi = (pix_in_data & LLT_BLK_MASK) + LLT_STEP;
            frac_d = pix_in_data[LLT_FRAC_W-1:0];
        end
    end

    // Sideband travels with the read so timing is unchanged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frac_q <= '0;
            s1_valid_q <= 1'b0;
            s1_last_q <= 1'b0;
            s1_raw_q <= LLT_RST_PIX;
        end else begin
            frac_q <= frac_d;
            s1_valid_q <= pix_in_valid;
            s1_last_q <= pix_in_last;
            s1_raw_q <= pix_in_data;
        end
    end

    // ------------------------------------------------------------------
    // Pixel stage 2: interpolation and output selection
    // ------------------------------------------------------------------
    logic [LLT_MIX_W-1:0] mix;
    logic [LLT_DATA_W-1:0] sub;
    logic [LLT_DATA_W-1:0] chosen;
    logic out_valid_d;
    logic out_last_d;
    logic [LLT_DATA_W-1:0] out_data_d;
    logic out_valid_q;
    logic out_last_q;
    logic [LLT_DATA_W-1:0] out_data_q;

    // Weighted sum of both neighbours over a step of eight; dropping the
    // three low bits truncates the fraction.  Widths are sized so the
    // largest sum, all ones times eight, cannot overflow.
    always_comb begin
        mix = LLT_MIX_W'(mif.rd_data_lo)
              * (LLT_MIX_W'(LLT_STEP) - LLT_MIX_W'(frac_q))
              + LLT_MIX_W'(mif.rd_data_hi) * LLT_MIX_W'(frac_q);
        sub = mix[LLT_MIX_W-1:LLT_FRAC_W];
    end

    // Substitute or raw value, then narrow for the 8-bit format.
    // Enable applies from the pixel taken in on the edge where the write completes.
    always_comb begin
        chosen = enable_q ? sub : s1_raw_q;
        out_valid_d = s1_valid_q;
        out_last_d = s1_last_q;
        if (fmt_q == LLT_FMT_MONO8) begin
            out_data_d = chosen >> LLT_NARROW_LSB;
        end else begin
            out_data_d = chosen;
        end
        last_sub_d = last_sub_q;
        if (s1_valid_q) begin
            last_sub_d = out_data_d;
        end
    end

    // Output register; two edges from input to output, always.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q <= 1'b0;
            out_last_q <= 1'b0;
            out_data_q <= LLT_RST_PIX;
            last_sub_q <= LLT_RST_PIX;
        end else begin
            out_valid_q <= out_valid_d;
            out_last_q <= out_last_d;
            out_data_q <= out_data_d;
            last_sub_q <= last_sub_d;
        end
    end

    assign pipe_busy = s1_valid_q || out_valid_q;
    assign pix_out_valid = out_valid_q;
    assign pix_out_last = out_last_q;
    assign pix_out_data = out_data_q;

endmodule

// [core/llt_pkg.sv]
package llt_pkg;

    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int LLT_DATA_W = 12;
    localparam int LLT_ADDR_W = 12;
    localparam int LLT_DEPTH = 4096;
    localparam int LLT_FRAC_W = 3;
    localparam int LLT_MIX_W = 15;
    localparam logic [LLT_ADDR_W-1:0] LLT_STEP = 12'h0008;
    localparam logic [LLT_ADDR_W-1:0] LLT_BLK_MASK = 12'h0FF8;
    localparam logic [LLT_ADDR_W-1:0] LLT_LAST_IDX = 12'h0FF8;
    localparam int LLT_NARROW_LSB = 4;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int LLT_APB_AW = 8;
    localparam int LLT_APB_DW = 32;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_SELECTOR = 8'h00;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_INDEX = 8'h04;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_VALUE = 8'h08;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_ENABLE = 8'h0C;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_FORMAT = 8'h10;
    localparam logic [LLT_APB_AW-1:0] LLT_OFS_STATUS = 8'h14;
    localparam int LLT_STAT_LAST_LSB = 16;

    // Only one table exists; its selector code.
    localparam logic [LLT_APB_DW-1:0] LLT_SEL_LUMINANCE = 32'h0000_0000;

    // Reset values.
    localparam logic [LLT_ADDR_W-1:0] LLT_RST_INDEX = 12'h000;
    localparam logic [LLT_DATA_W-1:0] LLT_RST_VALUE = 12'h000;
    localparam logic [LLT_DATA_W-1:0] LLT_RST_PIX = 12'h000;
    localparam logic [LLT_APB_DW-1:0] LLT_RST_RDATA = 32'h0000_0000;

    // Output pixel format.
    typedef enum logic {
        LLT_FMT_MONO12,
        LLT_FMT_MONO8
    } llt_fmt_t;

endpackage

// [core/llt_mem_if.sv]
// Carries table writes and the two interpolation reads to the memory.
interface llt_mem_if;
    import llt_pkg::*;

    logic wr_en;
    logic [LLT_ADDR_W-1:0] wr_addr;
    logic [LLT_DATA_W-1:0] wr_data;
    logic [LLT_ADDR_W-1:0] rd_addr_lo;
    logic [LLT_ADDR_W-1:0] rd_addr_hi;
    logic [LLT_DATA_W-1:0] rd_data_lo;
    logic [LLT_DATA_W-1:0] rd_data_hi;

    modport ctrl (
        output wr_en, wr_addr, wr_data, rd_addr_lo, rd_addr_hi,
        input rd_data_lo, rd_data_hi
    );
    modport mem (
        input wr_en, wr_addr, wr_data, rd_addr_lo, rd_addr_hi,
        output rd_data_lo, rd_data_hi
    );
endinterface

// [core/llt_table_mem.sv]
module llt_table_mem (
    // Clock.
    input wire logic pclk,
    // Table access.
    llt_mem_if.mem mif
);
    import llt_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // No reset on the array: contents are undefined until software loads
    // them, which is why loading must come before enabling.
    logic [LLT_DATA_W-1:0] table_q [LLT_DEPTH];
    logic [LLT_DATA_W-1:0] rd_lo_q;
    logic [LLT_DATA_W-1:0] rd_hi_q;

    // Every index is stored, including the ones the mapping never reads.
    always_ff @(posedge pclk) begin
        if (mif.wr_en) begin
            table_q[mif.wr_addr] <= mif.wr_data;
        end
    end

    // Two registered read ports feed one interpolation per clock.
    always_ff @(posedge pclk) begin
        rd_lo_q <= table_q[mif.rd_addr_lo];
        rd_hi_q <= table_q[mif.rd_addr_hi];
    end

    assign mif.rd_data_lo = rd_lo_q;
    assign mif.rd_data_hi = rd_hi_q;

endmodule

// [verif/llt_top_props.sv]
module llt_top_props (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [llt_pkg::LLT_APB_AW-1:0] paddr,
    input wire logic [llt_pkg::LLT_APB_DW-1:0] pwdata,
    input wire logic [llt_pkg::LLT_APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pixel streams.
    input wire logic pix_in_valid,
    input wire logic pix_in_last,
    input wire logic [llt_pkg::LLT_DATA_W-1:0] pix_in_data,
    input wire logic pix_out_valid,
    input wire logic pix_out_last,
    input wire logic [llt_pkg::LLT_DATA_W-1:0] pix_out_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import llt_pkg::*;

    // ------------------------------------------------------------------
    // Pixel timing
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_lat_valid;
        pix_out_valid == $past(pix_in_valid, 2);
    endproperty
    a_lat_valid: assert property (p_lat_valid)
        else $error("output valid does not follow input by two");
    property p_lat_last;
        pix_out_last == $past(pix_in_last, 2);
    endproperty
    a_lat_last: assert property (p_lat_last)
        else $error("output last does not follow input by two");

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    property p_rdy_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("no answer one cycle after access");
    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready held longer than one cycle");
    property p_rdy_cause;
        pready |-> $past(psel) && $past(penable) && psel && penable;
    endproperty
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("ready without an access phase");
    property p_rd_idle;
        !pready |-> prdata == LLT_RST_RDATA;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside answer");
    property p_sel_bad;
        pready && pwrite && paddr == LLT_OFS_SELECTOR
            && pwdata != LLT_SEL_LUMINANCE |-> pslverr;
    endproperty
    a_sel_bad: assert property (p_sel_bad)
        else $error("second table choice accepted");
    property p_sel_read;
        pready && !pwrite && paddr == LLT_OFS_SELECTOR
            |-> prdata == LLT_SEL_LUMINANCE && !pslverr;
    endproperty
    a_sel_read: assert property (p_sel_read)
        else $error("selector reads other than luminance");
    property p_unmapped;
        pready && paddr > LLT_OFS_STATUS |-> pslverr && prdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not refused");
endmodule

bind llt_top llt_top_props u_llt_top_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
    .pix_in_last(pix_in_last), .pix_in_data(pix_in_data),
    .pix_out_valid(pix_out_valid), .pix_out_last(pix_out_last),
    .pix_out_data(pix_out_data)
);

// [verif/llt_pix_model.sv]
module llt_pix_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Requests from the bench.
    input wire logic want,
    input wire logic want_last,
    input wire logic [llt_pkg::LLT_DATA_W-1:0] want_data,
    // Sensor stream toward the block.
    output logic pix_in_valid,
    output logic pix_in_last,
    output logic [llt_pkg::LLT_DATA_W-1:0] pix_in_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import llt_pkg::*;

    // Idle cycles carry inverted data, so a block that samples pixels
    // without looking at valid is caught as a wrong output value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_in_valid <= 1'b0;
            pix_in_last <= 1'b0;
            pix_in_data <= LLT_RST_PIX;
        end else begin
            pix_in_valid <= want;
            pix_in_last <= want & want_last;
            pix_in_data <= want ? want_data : ~pix_in_data;
        end
    end
endmodule

// [verif/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import llt_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic er_v, want, want_last, en_m, fmt_m;
    logic pix_in_valid, pix_in_last, pix_out_valid, pix_out_last;
    logic [11:0] pix_in_data, pix_out_data, want_data;
    logic [11:0] tbl [LLT_DEPTH];
    logic [12:0] expq [$];
    logic [12:0] e_v;
    logic [11:0] last_e;
    int fails, total_checks, seed;
    localparam logic [11:0] CORN [10] = '{12'h000, 12'h007, 12'h008,
        12'h00C, 12'h00F, 12'h010, 12'hFF7, 12'hFF8, 12'hFF9, 12'hFFF};

    llt_top u_llt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_in_valid(pix_in_valid),
        .pix_in_last(pix_in_last), .pix_in_data(pix_in_data),
        .pix_out_valid(pix_out_valid), .pix_out_last(pix_out_last),
        .pix_out_data(pix_out_data));
    llt_pix_model u_llt_pix_model (.pclk(pclk), .presetn(presetn),
        .want(want), .want_last(want_last), .want_data(want_data),
        .pix_in_valid(pix_in_valid), .pix_in_last(pix_in_last),
        .pix_in_data(pix_in_data));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Ready is taken at the rising edge, before that edge's updates land,
    // so the answer and the release belong to the same completing edge.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
        input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        check(rd_v, e);
        check({31'h0, er_v}, {31'h0, ee});
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d,
        input logic ee);
        apb(1'b1, a, d);
        check({31'h0, er_v}, {31'h0, ee});
    endtask

    function automatic logic [11:0] exp_pix(input logic [11:0] v);
        logic [11:0] lo;
        int acc;
        lo = v & LLT_BLK_MASK;
        if (!en_m)
            acc = v;
        else if (v >= LLT_LAST_IDX)
            acc = tbl[LLT_LAST_IDX];
        else
            acc = (tbl[lo] * (8 - v[2:0]) + tbl[lo + 8] * v[2:0]) / 8;
        if (fmt_m)
            acc = acc >> LLT_NARROW_LSB;
        return acc[11:0];
    endfunction

    // One pass of pixels under a fixed mode; gaps are random, so some
    // pixels go back to back.
    task automatic run(input logic en, input logic fmt);
        logic [11:0] v;
        en_m = en;
        fmt_m = fmt;
        wrc(LLT_OFS_FORMAT, {31'h0, fmt}, 1'b0);
        wrc(LLT_OFS_ENABLE, {31'h0, en}, 1'b0);
        for (int i = 0; i < 70; i++) begin
            v = (i < 10) ? CORN[i] : 12'($random(seed));
            @(posedge pclk);
            want <= 1'b1;
            want_data <= v;
            want_last <= (i % 9) == 8;
            expq.push_back({(i % 9) == 8, exp_pix(v)});
            if ($random(seed) & 1) begin
                @(posedge pclk);
                want <= 1'b0;
            end
        end
        @(posedge pclk);
        want <= 1'b0;
        repeat (6) @(posedge pclk);
        check(expq.size(), 0);
    endtask

    // Every output pixel is matched against the queue of expectations.
    always @(negedge pclk) begin
        if (pix_out_valid === 1'b1) begin
            e_v = (expq.size() > 0) ? expq.pop_front() : 13'h1FFF;
            last_e = e_v[11:0];
            check({19'h0_0000, pix_out_last, pix_out_data},
                {19'h0_0000, e_v});
        end
    end

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        #(25ns * 50000);
        fails++;
        results();
    end

    initial begin
        seed = 18;
        {presetn, psel, penable, pwrite, want, want_last} = '0;
        {paddr, pwdata, want_data, en_m, fmt_m} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(LLT_OFS_SELECTOR, LLT_SEL_LUMINANCE, 1'b0);
        rdc(LLT_OFS_INDEX, 32'h0000_0000, 1'b0);
        rdc(LLT_OFS_ENABLE, 32'h0000_0000, 1'b0);
        rdc(LLT_OFS_FORMAT, 32'h0000_0000, 1'b0);
        rdc(8'h18, 32'h0000_0000, 1'b1);
        wrc(LLT_OFS_SELECTOR, 32'h0000_0001, 1'b1);
        wrc(LLT_OFS_STATUS, 32'hFFFF_FFFF, 1'b0);
        run(1'b0, 1'b0);
        run(1'b0, 1'b1);
        // Table goes in whole before the enable is set.
        for (int i = 0; i < LLT_DEPTH; i++) begin
            tbl[i] = 12'($random(seed));
            wrc(LLT_OFS_INDEX, i, 1'b0);
            wrc(LLT_OFS_VALUE, {20'h0_0000, tbl[i]}, 1'b0);
        end
        rdc(LLT_OFS_INDEX, 32'h0000_0FFF, 1'b0);
        rdc(LLT_OFS_VALUE, {20'h0_0000, tbl[4095]}, 1'b0);
        run(1'b1, 1'b0);
        rdc(LLT_OFS_ENABLE, 32'h0000_0001, 1'b0);
        run(1'b1, 1'b1);
        // Off-grid rewrites must not move any output value.
        foreach (CORN[k]) begin
            if (CORN[k][2:0] != 3'h0) begin
                tbl[CORN[k]] = ~tbl[CORN[k]];
                wrc(LLT_OFS_INDEX, {20'h0_0000, CORN[k]}, 1'b0);
                wrc(LLT_OFS_VALUE, {20'h0_0000, tbl[CORN[k]]},
                    1'b0);
            end
        end
        run(1'b1, 1'b0);
        // Pipeline is drained, so only the last pixel shows in status.
        rdc(LLT_OFS_STATUS, {4'h0, last_e, 16'h0000}, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(LLT_OFS_ENABLE, 32'h0000_0000, 1'b0);
        results();
    end
endmodule
